// File: ccsm_clock_ctrl.sv
/*
  CPU clock source and mode control: setting flags, status flags and
  oscillator run enables.
  Assumes software obeys the legal mode transitions; the oscillators
  and the clock tree act on the enables it drives.
*/
// Operation
// - crystal mode: flags 0,0,1,0; subsystem 0, crystal 1; int osc by stop
// - internal mode: select flags 0, status 0; crystal stop select ignored
// - internal mode: crystal stops only through main-stop
// - crystal mode: neither stop flag stops the crystal
// - subsystem mode, all running: both status flags read 1
// - subsystem: crystal stop select stops crystal, internal osc runs
// - subsystem: internal stop stops internal osc, crystal runs
// - subsystem: both stop flags stop both oscillators
// - internal stop acts only when the software-stop option is built
// - subsystem mode: main-stop never stops the crystal
// - main-stop is bit 7 of the main oscillator control register
// - internal-stop is bit 0 of the internal oscillator mode register
// - crystal-active reads at bit 1 of the main clock mode register
// - subsystem-active reads at bit 5 of processor clock register
`timescale 1ns/100ps

module ccsm_clock_ctrl #(
  parameter bit INT_STOP_ALLOWED = 1'b1,
  parameter int SWITCH_DELAY = ccsm_pkg::SWITCH_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic xtal_run_o,
  output logic int_osc_run_o,
  output logic [1:0] cpu_src_o
);

  // the wait counter is four bits wide
  if (SWITCH_DELAY < 1 || SWITCH_DELAY > 15) begin : delay_check_g
    $error("SWITCH_DELAY out of range");
  end

  // ----------------------------------------------------------------
  // setting flags
  // ----------------------------------------------------------------
  ccsm_pkg::ccsm_flags_type flags, next_flags;

  always_comb begin
    next_flags = flags;
    if (wr_i) begin
      case (addr_i)
        ccsm_pkg::ADDR_PROC_CLK: begin
          next_flags.xstop_sel = wdata_i[ccsm_pkg::BIT_XSTOP_SEL];
          next_flags.sub_sel = wdata_i[ccsm_pkg::BIT_SUB_SEL];
        end
        ccsm_pkg::ADDR_MAIN_MODE: begin
          next_flags.main_src = wdata_i[ccsm_pkg::BIT_MAIN_SRC];
        end
        ccsm_pkg::ADDR_MAIN_OSC: begin
          next_flags.main_stop = wdata_i[ccsm_pkg::BIT_MAIN_STOP];
        end
        ccsm_pkg::ADDR_INT_OSC: begin
          next_flags.int_stop = wdata_i[ccsm_pkg::BIT_INT_STOP];
        end
        default: begin
          next_flags = flags;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flags.xstop_sel <= ccsm_pkg::RST_XSTOP_SEL;
      flags.sub_sel <= ccsm_pkg::RST_SUB_SEL;
      flags.main_src <= ccsm_pkg::RST_MAIN_SRC;
      flags.main_stop <= ccsm_pkg::RST_MAIN_STOP;
      flags.int_stop <= ccsm_pkg::RST_INT_STOP;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // active source: follows the selects after the switchover delay
  // ----------------------------------------------------------------
  ccsm_pkg::ccsm_mode_type mode, next_mode, target;
  logic [3:0] wait_cnt, next_wait_cnt;

  // subsystem select has priority: a stray main-source clear in
  // subsystem mode cannot reach the internal clock
  always_comb begin
    if (flags.sub_sel) begin
      target = ccsm_pkg::CCSM_SUB;
    end else if (flags.main_src) begin
      target = ccsm_pkg::CCSM_XTAL;
    end else begin
      target = ccsm_pkg::CCSM_INT;
    end
  end

  always_comb begin
    next_mode = mode;
    next_wait_cnt = wait_cnt;
    if (target == mode) begin
      next_wait_cnt = 4'h0;
    end else if (wait_cnt == 4'(SWITCH_DELAY - 1)) begin
      next_wait_cnt = 4'h0;
      case (mode)
        ccsm_pkg::CCSM_INT: begin
          // subsystem is reachable only via the crystal
          next_mode = ccsm_pkg::CCSM_XTAL;
        end
        ccsm_pkg::CCSM_XTAL: begin
          next_mode = target;
        end
        ccsm_pkg::CCSM_SUB: begin
          next_mode = ccsm_pkg::CCSM_XTAL;
        end
        default: begin
          next_mode = ccsm_pkg::CCSM_INT;
        end
      endcase
    end else begin
      next_wait_cnt = wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode <= ccsm_pkg::CCSM_INT;
      wait_cnt <= 4'h0;
    end else begin
      mode <= next_mode;
      wait_cnt <= next_wait_cnt;
    end
  end

  // ----------------------------------------------------------------
  // oscillator enables and read data
  // ----------------------------------------------------------------
  logic next_xtal_run, next_int_run;
  logic [1:0] next_cpu_src;
  logic [7:0] next_rdata;
  logic sub_act, xtal_act;

  always_comb begin
    sub_act = (mode == ccsm_pkg::CCSM_SUB);
    xtal_act = (mode != ccsm_pkg::CCSM_INT);
    case (mode)
      ccsm_pkg::CCSM_INT: begin
        next_xtal_run = !flags.main_stop;
        next_cpu_src = 2'h0;
      end
      ccsm_pkg::CCSM_XTAL: begin
        next_xtal_run = 1'b1;
        next_cpu_src = 2'h1;
      end
      ccsm_pkg::CCSM_SUB: begin
        next_xtal_run = !flags.xstop_sel;
        next_cpu_src = 2'h2;
      end
      default: begin
        next_xtal_run = 1'b1;
        next_cpu_src = 2'h0;
      end
    endcase
    // the internal clock may never stop while it drives the cpu
    next_int_run = !(INT_STOP_ALLOWED && flags.int_stop &&
                     mode != ccsm_pkg::CCSM_INT);
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ccsm_pkg::ADDR_PROC_CLK: begin
          next_rdata[ccsm_pkg::BIT_XSTOP_SEL] = flags.xstop_sel;
          next_rdata[ccsm_pkg::BIT_SUB_ACTIVE] = sub_act;
          next_rdata[ccsm_pkg::BIT_SUB_SEL] = flags.sub_sel;
        end
        ccsm_pkg::ADDR_MAIN_MODE: begin
          next_rdata[ccsm_pkg::BIT_XTAL_ACTIVE] = xtal_act;
          next_rdata[ccsm_pkg::BIT_MAIN_SRC] = flags.main_src;
        end
        ccsm_pkg::ADDR_MAIN_OSC: begin
          next_rdata[ccsm_pkg::BIT_MAIN_STOP] = flags.main_stop;
        end
        ccsm_pkg::ADDR_INT_OSC: begin
          next_rdata[ccsm_pkg::BIT_INT_STOP] = flags.int_stop;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      xtal_run_o <= 1'b0;
      int_osc_run_o <= 1'b1;
      cpu_src_o <= 2'h0;
      rdata_o <= 8'h00;
    end else begin
      xtal_run_o <= next_xtal_run;
      int_osc_run_o <= next_int_run;
      cpu_src_o <= next_cpu_src;
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence int_mode_s;
    mode == ccsm_pkg::CCSM_INT;
  endsequence

  sequence xtal_mode_s;
    mode == ccsm_pkg::CCSM_XTAL;
  endsequence

  sequence sub_mode_s;
    mode == ccsm_pkg::CCSM_SUB;
  endsequence

  // stop request that the build option lets through
  sequence int_stop_req_s;
    INT_STOP_ALLOWED && flags.int_stop;
  endsequence

  // ----------------------------------------------------------------
  // crystal enable
  // ----------------------------------------------------------------
  xtal_keeps_run_a: assert property (
    xtal_mode_s |=> xtal_run_o)
    else $error("crystal stopped while driving cpu");
  int_main_stop_a: assert property (
    int_mode_s |=> xtal_run_o == !$past(flags.main_stop))
    else $error("internal mode crystal enable wrong");
  sub_main_stop_a: assert property (
    sub_mode_s ##0 !flags.xstop_sel |=> xtal_run_o)
    else $error("main-stop stopped crystal in subsystem mode");
  sub_xstop_a: assert property (
    sub_mode_s ##0 flags.xstop_sel |=> !xtal_run_o)
    else $error("crystal stop select ignored in subsystem mode");

  // ----------------------------------------------------------------
  // internal oscillator enable
  // ----------------------------------------------------------------
  int_stop_opt_a: assert property (
    !(INT_STOP_ALLOWED && flags.int_stop) |=> int_osc_run_o)
    else $error("internal osc stopped without a stop request");
  int_keeps_run_a: assert property (
    int_mode_s |=> int_osc_run_o)
    else $error("internal osc stopped while driving cpu");
  xtal_int_run_a: assert property (
    xtal_mode_s ##0 !flags.int_stop |=> int_osc_run_o)
    else $error("internal osc stopped in crystal mode");
  xtal_int_stop_a: assert property (
    xtal_mode_s ##0 int_stop_req_s |=> !int_osc_run_o)
    else $error("internal stop ignored in crystal mode");
  sub_int_run_a: assert property (
    sub_mode_s ##0 !flags.int_stop |=> int_osc_run_o)
    else $error("internal osc stopped in subsystem mode");
  sub_int_stop_a: assert property (
    sub_mode_s ##0 int_stop_req_s |=> !int_osc_run_o)
    else $error("internal stop ignored in subsystem mode");

  // ----------------------------------------------------------------
  // cpu source, mode steps and status reads
  // ----------------------------------------------------------------
  int_src_a: assert property (
    int_mode_s |=> cpu_src_o == 2'h0)
    else $error("internal mode source wrong");
  xtal_src_a: assert property (
    xtal_mode_s |=> cpu_src_o == 2'h1)
    else $error("crystal mode source wrong");
  sub_src_a: assert property (
    sub_mode_s |=> cpu_src_o == 2'h2)
    else $error("subsystem mode source wrong");
  int_never_sub_a: assert property (
    int_mode_s |=> mode != ccsm_pkg::CCSM_SUB)
    else $error("direct internal to subsystem");
  sub_exit_a: assert property (
    sub_mode_s |=> mode != ccsm_pkg::CCSM_INT)
    else $error("subsystem to internal directly");
  status_read_a: assert property (
    rd_i && addr_i == ccsm_pkg::ADDR_PROC_CLK
    |=> rdata_o[ccsm_pkg::BIT_SUB_ACTIVE] == $past(sub_act))
    else $error("subsystem-active read wrong");
  sub_stat_clr_a: assert property (
    rd_i && addr_i == ccsm_pkg::ADDR_PROC_CLK && mode != ccsm_pkg::CCSM_SUB
    |=> !rdata_o[ccsm_pkg::BIT_SUB_ACTIVE])
    else $error("subsystem-active set off the subsystem clock");
  xtal_stat_read_a: assert property (
    rd_i && addr_i == ccsm_pkg::ADDR_MAIN_MODE && mode != ccsm_pkg::CCSM_INT
    |=> rdata_o[ccsm_pkg::BIT_XTAL_ACTIVE])
    else $error("crystal-active clear off the internal clock");
  int_mode_stat_a: assert property (
    rd_i && addr_i == ccsm_pkg::ADDR_MAIN_MODE && mode == ccsm_pkg::CCSM_INT
    |=> !rdata_o[ccsm_pkg::BIT_XTAL_ACTIVE])
    else $error("crystal-active set in internal mode");

endmodule

// File: ccsm_osc_model.sv
/*
  Behavioural model of the oscillators and the cpu clock tree.
  Assumes the run enables and source code of the clock control block.
*/
`timescale 1ns/100ps

module ccsm_osc_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic xtal_run_i,
  input wire logic int_osc_run_i,
  input wire logic [1:0] cpu_src_i,
  output logic sub_stable_o,
  output logic cpu_dead_o
);
  logic [3:0] settle;

  // ----------------------------------------------------------------
  // subsystem oscillator settling and cpu clock loss
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      settle <= 4'h0;
      cpu_dead_o <= 1'b0;
    end else begin
      if (settle != 4'hF) begin
        settle <= settle + 4'h1;
      end
      // sticky, so a short glitch of the source is not missed
      if ((cpu_src_i == 2'h0 && !int_osc_run_i) ||
          (cpu_src_i == 2'h1 && !xtal_run_i)) begin
        cpu_dead_o <= 1'b1;
      end
    end
  end

  assign sub_stable_o = (settle == 4'hF);
endmodule

// File: ccsm_pkg.sv
/*
  Package for the CPU clock source and mode control block.
  Holds register offsets, field positions, reset values and timing.
  Assumes a plain register port with one-cycle read latency.
*/
package ccsm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_PROC_CLK = 2'h0;
  localparam logic [1:0] ADDR_MAIN_MODE = 2'h1;
  localparam logic [1:0] ADDR_MAIN_OSC = 2'h2;
  localparam logic [1:0] ADDR_INT_OSC = 2'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_XSTOP_SEL = 7;
  localparam int BIT_SUB_ACTIVE = 5;
  localparam int BIT_SUB_SEL = 4;
  localparam int BIT_MAIN_STOP = 7;
  localparam int BIT_XTAL_ACTIVE = 1;
  localparam int BIT_MAIN_SRC = 0;
  localparam int BIT_INT_STOP = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_XSTOP_SEL = 1'h0;
  localparam logic RST_SUB_SEL = 1'h0;
  localparam logic RST_MAIN_SRC = 1'h0;
  localparam logic RST_MAIN_STOP = 1'h1;
  localparam logic RST_INT_STOP = 1'h0;

  // ----------------------------------------------------------------
  // switchover delay in cpu clocks
  // ----------------------------------------------------------------
  localparam int SWITCH_CYCLES = 2;

  typedef enum {
    CCSM_INT,
    CCSM_XTAL,
    CCSM_SUB
  } ccsm_mode_type;

  typedef struct packed {
    logic xstop_sel;
    logic sub_sel;
    logic main_src;
    logic main_stop;
    logic int_stop;
  } ccsm_flags_type;

endpackage

// File: cpu_clock_source_mode_control_test.sv
/*
  Self-checking bench for the cpu clock source and mode control.
  Assumes the register port of the block and the oscillator model.
*/
`timescale 1ns/100ps

module cpu_clock_source_mode_control_test;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic xtal_run_o, int_osc_run_o, sub_stable, cpu_dead;
  logic [1:0] cpu_src_o;
  int err_count = 0;
  int num_checks = 0;

  ccsm_clock_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .xtal_run_o(xtal_run_o),
    .int_osc_run_o(int_osc_run_o), .cpu_src_o(cpu_src_o));
  ccsm_osc_model osc_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .xtal_run_i(xtal_run_o), .int_osc_run_i(int_osc_run_o),
    .cpu_src_i(cpu_src_o), .sub_stable_o(sub_stable),
    .cpu_dead_o(cpu_dead));

  always #25 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %0d", a), exp, rdata_o);
  endtask

  // levels settle a few cycles after the last write
  task automatic outs(input logic [1:0] s, input logic x, input logic i);
    repeat (4) @(posedge mclk_i);
    #1;
    chk("cpu_src", {6'h00, s}, {6'h00, cpu_src_o});
    chk("xtal_run", {7'h00, x}, {7'h00, xtal_run_o});
    chk("int_osc_run", {7'h00, i}, {7'h00, int_osc_run_o});
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    #1;
    while (cpu_src_o !== s && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (cpu_src_o !== s) begin
      err_count++;
      $display("BAD cpu_src wait expected %h seen %h", s, cpu_src_o);
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    outs(2'h0, 1'b0, 1'b1);
    rd(ccsm_pkg::ADDR_MAIN_OSC, 8'h80);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h20);
    rd(ccsm_pkg::ADDR_PROC_CLK, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h00);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h80);
    outs(2'h0, 1'b1, 1'b1);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_MODE, 8'h01);
    wait_src(2'h1);
    rd(ccsm_pkg::ADDR_MAIN_MODE, 8'h03);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h80);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h80);
    outs(2'h1, 1'b1, 1'b1);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h00);
    wr(ccsm_pkg::ADDR_INT_OSC, 8'h01);
    outs(2'h1, 1'b1, 1'b0);
    rd(ccsm_pkg::ADDR_INT_OSC, 8'h01);
    wr(ccsm_pkg::ADDR_INT_OSC, 8'h00);
    n = 0;
    while (!sub_stable && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (!sub_stable) begin
      err_count++;
      $display("BAD sub_stable wait expected 1 seen %b", sub_stable);
      end_sim();
    end
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h10);
    wait_src(2'h2);
    rd(ccsm_pkg::ADDR_PROC_CLK, 8'h30);
    rd(ccsm_pkg::ADDR_MAIN_MODE, 8'h03);
    outs(2'h2, 1'b1, 1'b1);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h90);
    outs(2'h2, 1'b0, 1'b1);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h10);
    wr(ccsm_pkg::ADDR_INT_OSC, 8'h01);
    outs(2'h2, 1'b1, 1'b0);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h90);
    outs(2'h2, 1'b0, 1'b0);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h10);
    wr(ccsm_pkg::ADDR_INT_OSC, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h80);
    outs(2'h2, 1'b1, 1'b1);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h00);
    wr(ccsm_pkg::ADDR_PROC_CLK, 8'h00);
    wait_src(2'h1);
    rd(ccsm_pkg::ADDR_PROC_CLK, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_MODE, 8'h00);
    wait_src(2'h0);
    rd(ccsm_pkg::ADDR_MAIN_MODE, 8'h00);
    wr(ccsm_pkg::ADDR_MAIN_OSC, 8'h80);
    outs(2'h0, 1'b0, 1'b1);
    chk("cpu_dead", 8'h00, {7'h00, cpu_dead});
    end_sim();
  end
endmodule
